/* dv/temp_sensor_conversion_control_tb.sv */
// Self-checking bench for the conversion control block
`timescale 1ns/1ps
`default_nettype none
module temp_sensor_conversion_control_tb;
   localparam logic [6:0] DEV = {4'h4, 3'b101};
   logic core_clk = 1'b0;
   logic arst_n = 1'b0;
   logic conversion_start_n = 1'b1;
   logic reference_input = 1'b0;
   logic [9:0] sar_code = 10'h000;
   logic [31:0] seed = 32'h135fd024;
   logic scl, host_oe, sda_oe, sda_out, track_hold, ref_amp_en;
   logic int_ref_sel, power_down, over_temp;
   logic [2:0] mux_sel;
   logic [2:0] asel = 3'b101;
   int n_fail = 0;
   int checks_done = 0;
   int th_len = 0;
   int n;
   logic [15:0] exp_q[$];
   int len_q[$];
   // Open-drain data line with pull-up
   wire logic sda = (host_oe || (sda_oe && !sda_out)) ? 1'b0 : 1'b1;
   always #2.5 core_clk = ~core_clk;
   tsc_conv_ctrl #(.TEMP_CONV_CYC(40), .AUTO_PERIOD_CYC(2000),
      .BUS_ADDR_HI(4'h4)) DUT (.core_clk(core_clk), .arst_n(arst_n),
      .bus_clk(scl), .bus_scl_in(scl), .bus_sda_in(sda),
      .bus_sda_out(sda_out), .bus_sda_oe(sda_oe), .bus_addr_sel_bit0(asel[0]),
      .bus_addr_sel_bit1(asel[1]), .bus_addr_sel_bit2(asel[2]),
      .conversion_start_n(conversion_start_n),
      .reference_input(reference_input), .sar_code(sar_code),
      .track_hold(track_hold), .ref_amp_en(ref_amp_en),
      .int_ref_sel(int_ref_sel), .power_down(power_down),
      .mux_sel(mux_sel), .over_temp(over_temp));
   tsc_i2c_host host (.scl(scl), .sda_oe(host_oe), .sda(sda));
   task automatic chk(input string nm, input logic [15:0] e,
      input logic [15:0] g);
      checks_done++;
      if (g !== e) begin
         n_fail++;
         $display("mismatch %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", checks_done, n_fail);
      if (n_fail == 0 && checks_done > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   function automatic logic [31:0] lfsr(input logic [31:0] x);
      return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
   endfunction
   task automatic rd(input logic [2:0] p, input logic [15:0] e);
      exp_q.push_back(e);
      host.rd(DEV, {5'h00, p});
   endtask
   // Start-pin conversion; go low means it must be refused
   task automatic conv(input logic [9:0] c, input int len, input logic go);
      @(negedge core_clk) sar_code = c;
      if (go) len_q.push_back(len);
      conversion_start_n = 1'b0;
      repeat (4) @(negedge core_clk);
      conversion_start_n = 1'b1;
      repeat (20) if (track_hold !== 1'b1) @(negedge core_clk);
      chk("hold", go, track_hold);
      chk("pwr", !go, power_down);
      if (go) chk("amp", !reference_input, ref_amp_en);
      if (go) chk("iref", !reference_input, int_ref_sel);
      repeat (len + 10) if (track_hold === 1'b1) @(negedge core_clk);
      repeat (100) @(negedge core_clk);
      chk("pwr", 1'b1, power_down);
      chk("amp", 1'b0, ref_amp_en);
   endtask
   // Conversion length against the oldest expectation
   always @(negedge core_clk) begin
      if (track_hold === 1'b1) th_len <= th_len + 1;
      else begin
         if (th_len != 0 && len_q.size() != 0)
            chk("len", 16'(len_q.pop_front()), th_len[15:0]);
         th_len <= 0;
      end
   end
   // Register reads against the oldest expectation
   always begin
      @(host.rd_done);
      chk("reg", exp_q.pop_front(), host.rd_data);
   end
   // Watchdog
   initial begin
      #400000;
      n_fail++;
      tally_and_finish();
   end
   // Main sequence
   initial begin
      repeat (16) @(posedge core_clk);
      @(negedge core_clk) arst_n = 1'b1;
      chk("pwr", 1'b1, power_down);
      chk("mux", 3'h0, mux_sel);
      rd(3'h0, tsc_pkg::RESULT_RST);
      rd(3'h2, tsc_pkg::THYST_RST);
      rd(3'h3, tsc_pkg::TOTI_RST);
      rd(3'h6, 16'h0000);
      host.wr(DEV, 8'h05, 16'h8000, 1);
      chk("ack", 1'b0, host.nack);
      host.wr({4'h4, 3'b100}, 8'h05, 16'h0000, 1);
      chk("nack", 1'b1, host.nack);
      asel = 3'b100;
      host.wr({4'h4, 3'b100}, 8'h05, 16'h8000, 1);
      chk("ack", 1'b0, host.nack);
      asel = 3'b101;
      // Let the conversion started by the mode write finish
      repeat (400) @(negedge core_clk);
      seed = lfsr(seed);
      conv(seed[9:0], 40, 1'b1);
      rd(3'h0, {seed[9:0], 6'h00});
      conv(10'h150, 40, 1'b1);
      chk("ot", 1'b0, over_temp);
      conv(10'h3f0, 40, 1'b1);
      chk("ot", 1'b1, over_temp);
      host.wr(DEV, 8'h01, 16'h8000, 1);
      repeat (10) @(negedge core_clk);
      chk("mux", 3'h4, mux_sel);
      conv(10'h155, tsc_pkg::ADC_CONV_CYC, 1'b1);
      rd(3'h0, {10'h3f0, 6'h00});
      // Host scales the negative reading to whole degrees
      chk("degc", 16'hfffc, 16'((int'(host.rd_data[14:6]) - 512) / 4));
      rd(3'h4, {10'h155, 6'h00});
      @(negedge core_clk) reference_input = 1'b1;
      host.wr(DEV, 8'h01, 16'h0000, 1);
      conv(10'h100, 40, 1'b1);
      @(negedge core_clk) reference_input = 1'b0;
      host.wr(DEV, 8'h01, 16'h0100, 1);
      conv(10'h100, 40, 1'b0);
      host.wr(DEV, 8'h01, 16'h0400, 1);
      repeat (4) @(negedge core_clk);
      chk("ot", 1'b0, over_temp);
      host.wr(DEV, 8'h05, 16'h0000, 1);
      repeat (2700) if (track_hold !== 1'b1) @(negedge core_clk);
      repeat (60) if (track_hold === 1'b1) @(negedge core_clk);
      n = 0;
      repeat (2100) if (track_hold !== 1'b1) begin
         @(negedge core_clk);
         n++;
      end
      // Period runs start to start, so the idle gap lacks the conversion
      chk("period", 1'b1, n >= 1958 && n <= 1962);
      repeat (60) if (track_hold === 1'b1) @(negedge core_clk);
      fork
         host.wr(DEV, 8'h01, 16'h0000, 1);
         begin
            @(host.stop_done);
            n = 0;
            repeat (700) if (track_hold !== 1'b1) begin
               @(negedge core_clk);
               n++;
            end
         end
      join
      chk("auto", 1'b1, n >= 601 && n <= 610);
      tally_and_finish();
   end
endmodule
`default_nettype wire

/* dv/tsc_i2c_host.sv */
// Two-wire bus host model issuing register frames
`timescale 1ns/1ps
`default_nettype none
module tsc_i2c_host (
   output logic scl,
   output logic sda_oe,
   input wire logic sda
);
   logic [15:0] rd_data;
   logic nack;
   event rd_done;
   event stop_done;
   // Idle bus: clock stands high, data left to the pull-up
   initial begin
      scl = 1'b1;
      sda_oe = 1'b0;
   end
   // One bit: data moves while clock low, sampled at end of high
   task automatic bit_io(input logic b, output logic s);
      sda_oe = ~b;
      #20 scl = 1'b1;
      #40 s = sda;
      scl = 1'b0;
      #20;
   endtask
   // Eight bits MSB first, then the acknowledge slot
   task automatic byte_io(input logic [7:0] tx, input logic rel,
      output logic [7:0] rx, output logic a);
      for (int i = 7; i >= 0; i--) bit_io(tx[i], rx[i]);
      bit_io(rel, a);
   endtask
   // Start with long setup so the link side leaves reset
   task automatic start();
      sda_oe = 1'b1;
      #60 scl = 1'b0;
      #20;
   endtask
   task automatic stop();
      sda_oe = 1'b1;
      #20 scl = 1'b1;
      #40 sda_oe = 1'b0;
      -> stop_done;
      #40;
   endtask
   // Address, pointer, then nb data bytes high first
   task automatic wr(input logic [6:0] dev, input logic [7:0] ptr,
      input logic [15:0] v, input int nb);
      logic [7:0] r;
      logic a;
      start();
      byte_io({dev, 1'b0}, 1'b1, r, a);
      nack = a;
      if (!a) begin
         byte_io(ptr, 1'b1, r, a);
         if (nb > 0) byte_io(v[15:8], 1'b1, r, a);
         if (nb > 1) byte_io(v[7:0], 1'b1, r, a);
      end
      stop();
   endtask
   // Pointer frame, then two bytes read, the last refused
   task automatic rd(input logic [6:0] dev, input logic [7:0] ptr);
      logic [7:0] r;
      logic a;
      wr(dev, ptr, 16'h0000, 0);
      start();
      byte_io({dev, 1'b1}, 1'b1, r, a);
      byte_io(8'hff, 1'b0, rd_data[15:8], a);
      byte_io(8'hff, 1'b1, rd_data[7:0], a);
      stop();
      -> rd_done;
   endtask
endmodule
`default_nettype wire

/* hw/tsc_conv_ctrl.sv */
// Conversion sequencing, result formatting and serial register access
`timescale 1ns/1ps
`default_nettype none
module tsc_conv_ctrl #(
   parameter int TEMP_CONV_CYC = tsc_pkg::TEMP_CONV_CYC,
   parameter int AUTO_PERIOD_CYC = tsc_pkg::AUTO_PERIOD_CYC,
   parameter logic [3:0] BUS_ADDR_HI = 4'h4 // Arbitrary value
) (
   input wire logic core_clk,
   input wire logic arst_n,
   input wire logic bus_clk,
   input wire logic bus_scl_in,
   input wire logic bus_sda_in,
   output logic bus_sda_out,
   output logic bus_sda_oe,
   input wire logic bus_addr_sel_bit0,
   input wire logic bus_addr_sel_bit1,
   input wire logic bus_addr_sel_bit2,
   input wire logic conversion_start_n,
   input wire logic reference_input,
   input wire logic [9:0] sar_code,
   output logic track_hold,
   output logic ref_amp_en,
   output logic int_ref_sel,
   output logic power_down,
   output logic [2:0] mux_sel,
   output logic over_temp
);
   // Core domain state
   logic [3:0] pin_s1_reg, pin_s2_reg, pin_s3_reg, pin_f_reg, pin_f_next;
   logic [9:0] code_s1_reg, code_s2_reg, code_s3_reg, code_f_reg;
   logic frame_active_reg, link_rst_n_reg, link_rst_n_next;
   logic [7:0] cfg_core_reg, cfg2_core_reg;
   logic [15:0] thyst_core_reg, toti_core_reg;
   tsc_pkg::tsc_state_t state_reg, state_next;
   logic [16:0] cnt_reg, cnt_next, auto_cnt_reg, auto_cnt_next;
   logic [2:0] conv_chan_reg;
   logic pend_reg, pend_temp_reg;
   logic [9:0] pend_code_reg;
   logic [15:0] temp_reading_reg, adc_reg;
   logic over_reg, over_next;
   logic track_hold_reg, ref_amp_en_reg, int_ref_sel_reg, power_down_reg;
   logic [2:0] mux_sel_reg;
   logic over_temp_reg;
   // Link domain state
   logic [2:0] asel_s1_reg, asel_s2_reg, asel_s3_reg, asel_f_reg;
   logic [3:0] bit_cnt_reg;
   logic [6:0] rx_reg;
   logic [1:0] byte_idx_reg;
   logic matched_reg, rd_reg, sda_oe_reg, sda_out_reg;
   logic [2:0] ptr_reg;
   logic [7:0] cfg_lnk_reg, cfg2_lnk_reg;
   logic [15:0] thyst_lnk_reg, toti_lnk_reg;

   // Pin filter: a change counts once second and third stage agree
   assign pin_f_next = (pin_s2_reg & pin_s3_reg)
                     | (pin_f_reg & (pin_s2_reg ^ pin_s3_reg));
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         pin_s1_reg <= 4'hf;
         pin_s2_reg <= 4'hf;
         pin_s3_reg <= 4'hf;
         pin_f_reg <= 4'hf;
         code_s1_reg <= 10'h000;
         code_s2_reg <= 10'h000;
         code_s3_reg <= 10'h000;
         code_f_reg <= 10'h000;
      end else begin
         pin_s1_reg <= {reference_input, conversion_start_n,
                        bus_sda_in, bus_scl_in};
         pin_s2_reg <= pin_s1_reg;
         pin_s3_reg <= pin_s2_reg;
         pin_f_reg <= pin_f_next;
         code_s1_reg <= sar_code;
         code_s2_reg <= code_s1_reg;
         code_s3_reg <= code_s2_reg;
         if (code_s2_reg == code_s3_reg) begin
            code_f_reg <= code_s3_reg;
         end
      end
   end

   // Bus start and stop seen from the filtered pins
   wire scl_high = pin_f_reg[tsc_pkg::PIN_SCL]
                 & pin_f_next[tsc_pkg::PIN_SCL];
   wire start_det = scl_high & pin_f_reg[tsc_pkg::PIN_SDA]
                  & ~pin_f_next[tsc_pkg::PIN_SDA];
   wire stop_det = scl_high & ~pin_f_reg[tsc_pkg::PIN_SDA]
                 & pin_f_next[tsc_pkg::PIN_SDA];
   wire cst_fall = pin_f_reg[tsc_pkg::PIN_CST]
                 & ~pin_f_next[tsc_pkg::PIN_CST];
   wire ext_ref = pin_f_reg[tsc_pkg::PIN_REF];
   // Link logic held in reset while idle, pulsed on repeated start
   assign link_rst_n_next = stop_det ? 1'b0 :
                            start_det ? ~frame_active_reg :
                            frame_active_reg ? 1'b1 : link_rst_n_reg;

   // Frame tracking and snapshot of host-written settings after each frame
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         frame_active_reg <= 1'b0;
         link_rst_n_reg <= 1'b0;
         cfg_core_reg <= tsc_pkg::CFG_RST;
         cfg2_core_reg <= tsc_pkg::CFG2_RST;
         thyst_core_reg <= tsc_pkg::THYST_RST;
         toti_core_reg <= tsc_pkg::TOTI_RST;
      end else begin
         link_rst_n_reg <= link_rst_n_next;
         if (start_det) begin
            frame_active_reg <= 1'b1;
         end else if (stop_det) begin
            frame_active_reg <= 1'b0;
         end
         if (stop_det) begin
            cfg_core_reg <= cfg_lnk_reg;
            cfg2_core_reg <= cfg2_lnk_reg;
            thyst_core_reg <= thyst_lnk_reg;
            toti_core_reg <= toti_lnk_reg;
         end
      end
   end

   // Conversion triggers and internally timed sequence
   wire [2:0] cfg_chan = cfg_core_reg[tsc_pkg::CFG_CHAN_LSB +: 3];
   wire shutdown = cfg_core_reg[tsc_pkg::CFG_SHDN_BIT];
   wire pin_mode = cfg2_core_reg[tsc_pkg::CFG2_MODE_BIT];
   wire auto_on = ~pin_mode & ~shutdown;
   wire is_idle = (state_reg == tsc_pkg::ST_IDLE);
   wire pin_go = cst_fall & ~shutdown & is_idle;
   wire access_go = stop_det & auto_on & is_idle;
   wire timer_go = auto_on & is_idle
                 & (auto_cnt_reg == 17'(AUTO_PERIOD_CYC - 1));
   wire hold_done = (state_reg == tsc_pkg::ST_WAIT)
                  & (cnt_reg == 17'(tsc_pkg::HOLD_CYC - 1));
   wire [16:0] conv_last = (conv_chan_reg == tsc_pkg::TEMP_CHAN)
                         ? 17'(TEMP_CONV_CYC - 1)
                         : 17'(tsc_pkg::ADC_CONV_CYC - 1);
   wire conv_done = (state_reg == tsc_pkg::ST_CONV)
                  & (cnt_reg == conv_last);
   wire conv_go = pin_go | timer_go | hold_done;

   // Next state of the sequencer
   always_comb begin
      state_next = state_reg;
      cnt_next = cnt_reg + 17'h00001;
      unique case (state_reg)
         tsc_pkg::ST_IDLE: begin
            cnt_next = 17'h00000;
            if (pin_go || timer_go) begin
               state_next = tsc_pkg::ST_CONV;
            end else if (access_go) begin
               state_next = tsc_pkg::ST_WAIT;
            end
         end
         tsc_pkg::ST_WAIT: begin
            if (hold_done) begin
               state_next = tsc_pkg::ST_CONV;
               cnt_next = 17'h00000;
            end
         end
         tsc_pkg::ST_CONV: begin
            if (conv_done) begin
               state_next = tsc_pkg::ST_IDLE;
               cnt_next = 17'h00000;
            end
         end
      endcase
   end

   // Automatic period timer restarts at every conversion start
   assign auto_cnt_next = (!auto_on || conv_go) ? 17'h00000 :
      (auto_cnt_reg == 17'(AUTO_PERIOD_CYC - 1)) ? auto_cnt_reg :
      auto_cnt_reg + 17'h00001;

   // Sequencer registers and analog control outputs
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         state_reg <= tsc_pkg::ST_IDLE;
         cnt_reg <= 17'h00000;
         auto_cnt_reg <= 17'h00000;
         conv_chan_reg <= tsc_pkg::TEMP_CHAN;
         track_hold_reg <= 1'b0;
         ref_amp_en_reg <= 1'b0;
         int_ref_sel_reg <= 1'b0;
         power_down_reg <= 1'b1;
         mux_sel_reg <= tsc_pkg::TEMP_CHAN;
      end else begin
         state_reg <= state_next;
         cnt_reg <= cnt_next;
         auto_cnt_reg <= auto_cnt_next;
         if (conv_go) begin
            conv_chan_reg <= cfg_chan;
         end
         track_hold_reg <= (state_next == tsc_pkg::ST_CONV);
         ref_amp_en_reg <= (state_next == tsc_pkg::ST_CONV)
                         & ~ext_ref;
         int_ref_sel_reg <= ~ext_ref;
         power_down_reg <= (state_next == tsc_pkg::ST_IDLE);
         mux_sel_reg <= cfg_chan;
      end
   end

   // Results wait for an idle bus so no read sees a torn word
   wire apply = pend_reg & ~frame_active_reg & ~start_det;
   wire over_lim = $signed(pend_code_reg[9:1])
                >= $signed(toti_core_reg[15:tsc_pkg::SETP_LSB]);
   wire under_hyst = $signed(pend_code_reg[9:1])
                   < $signed(thyst_core_reg[15:tsc_pkg::SETP_LSB]);
   assign over_next = (apply && pend_temp_reg) ?
      (over_lim | (over_reg & ~under_hyst)) : over_reg;
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         pend_reg <= 1'b0;
         pend_temp_reg <= 1'b0;
         pend_code_reg <= 10'h000;
         temp_reading_reg <= tsc_pkg::RESULT_RST;
         adc_reg <= tsc_pkg::RESULT_RST;
         over_reg <= 1'b0;
         over_temp_reg <= 1'b0;
      end else begin
         over_reg <= over_next;
         over_temp_reg <= over_next ~^ cfg_core_reg[tsc_pkg::CFG_POL_BIT];
         if (apply && pend_temp_reg) begin
            temp_reading_reg <= {pend_code_reg, 6'h00};
         end else if (apply) begin
            adc_reg <= {pend_code_reg, 6'h00};
         end
         if (conv_done) begin
            pend_reg <= 1'b1;
            pend_code_reg <= code_f_reg;
            pend_temp_reg <= (conv_chan_reg == tsc_pkg::TEMP_CHAN);
         end else if (apply) begin
            pend_reg <= 1'b0;
         end
      end
   end

   // Address select straps on the link clock
   always_ff @(posedge bus_clk or negedge arst_n) begin
      if (!arst_n) begin
         asel_s1_reg <= 3'h0;
         asel_s2_reg <= 3'h0;
         asel_s3_reg <= 3'h0;
         asel_f_reg <= 3'h0;
      end else begin
         asel_s1_reg <= {bus_addr_sel_bit2, bus_addr_sel_bit1,
                         bus_addr_sel_bit0};
         asel_s2_reg <= asel_s1_reg;
         asel_s3_reg <= asel_s2_reg;
         asel_f_reg <= (asel_s2_reg & asel_s3_reg)
                     | (asel_f_reg & (asel_s2_reg ^ asel_s3_reg));
      end
   end

   // Serial byte decode
   wire [7:0] rx_byte = {rx_reg, bus_sda_in};
   wire byte_end = (bit_cnt_reg == tsc_pkg::BIT_LAST);
   wire ack_slot = (bit_cnt_reg == tsc_pkg::BIT_ACK);
   wire addr_hit = (rx_byte[7:1] == {BUS_ADDR_HI, asel_f_reg});
   wire wr_byte = byte_end & matched_reg & ~rd_reg;
   wire wr_ptr = wr_byte & (byte_idx_reg == 2'd1);
   wire wr_hi = wr_byte & (byte_idx_reg == 2'd2);
   wire wr_lo = wr_byte & (byte_idx_reg == 2'd3);

   // Serial framing, reset while the bus is idle
   always_ff @(posedge bus_clk or negedge link_rst_n_reg) begin
      if (!link_rst_n_reg) begin
         bit_cnt_reg <= 4'h0;
         rx_reg <= 7'h00;
         byte_idx_reg <= 2'd0;
         matched_reg <= 1'b0;
         rd_reg <= 1'b0;
      end else begin
         bit_cnt_reg <= ack_slot ? 4'h0 : bit_cnt_reg + 4'h1;
         if (!ack_slot) begin
            rx_reg <= rx_byte[6:0];
         end
         if (byte_end && byte_idx_reg == 2'd0) begin
            matched_reg <= addr_hit;
            rd_reg <= rx_byte[0];
         end
         if (ack_slot && rd_reg && byte_idx_reg != 2'd0 && bus_sda_in) begin
            matched_reg <= 1'b0;
         end
         if (ack_slot && byte_idx_reg != 2'd3) begin
            byte_idx_reg <= byte_idx_reg + 2'd1;
         end
      end
   end

   // Host-writable registers, kept across frames
   always_ff @(posedge bus_clk or negedge arst_n) begin
      if (!arst_n) begin
         ptr_reg <= tsc_pkg::REG_TEMP;
         cfg_lnk_reg <= tsc_pkg::CFG_RST;
         cfg2_lnk_reg <= tsc_pkg::CFG2_RST;
         thyst_lnk_reg <= tsc_pkg::THYST_RST;
         toti_lnk_reg <= tsc_pkg::TOTI_RST;
      end else begin
         if (wr_ptr) begin
            ptr_reg <= rx_byte[2:0];
         end
         if (wr_hi && ptr_reg == tsc_pkg::REG_CFG) begin
            cfg_lnk_reg <= rx_byte;
         end
         if (wr_hi && ptr_reg == tsc_pkg::REG_CFG2) begin
            cfg2_lnk_reg <= {rx_byte[7:6], 6'h00};
         end
         if (wr_hi && ptr_reg == tsc_pkg::REG_THYST) begin
            thyst_lnk_reg[15:8] <= rx_byte;
         end
         if (wr_lo && ptr_reg == tsc_pkg::REG_THYST) begin
            thyst_lnk_reg[7:0] <= {rx_byte[7], 7'h00};
         end
         if (wr_hi && ptr_reg == tsc_pkg::REG_TOTI) begin
            toti_lnk_reg[15:8] <= rx_byte;
         end
         if (wr_lo && ptr_reg == tsc_pkg::REG_TOTI) begin
            toti_lnk_reg[7:0] <= {rx_byte[7], 7'h00};
         end
      end
   end

   // Read word; core results are stable while a frame runs
   wire [15:0] rd_word =
      (ptr_reg == tsc_pkg::REG_TEMP) ? temp_reading_reg :
      (ptr_reg == tsc_pkg::REG_CFG) ? {cfg_lnk_reg, 8'h00} :
      (ptr_reg == tsc_pkg::REG_THYST) ? thyst_lnk_reg :
      (ptr_reg == tsc_pkg::REG_TOTI) ? toti_lnk_reg :
      (ptr_reg == tsc_pkg::REG_ADC) ? adc_reg :
      (ptr_reg == tsc_pkg::REG_CFG2) ? {cfg2_lnk_reg, 8'h00} : 16'h0000;
   wire [3:0] tx_idx = ((byte_idx_reg == 2'd1) ? 4'hf : 4'h7) - bit_cnt_reg;
   wire do_ack = ack_slot & matched_reg
               & ((byte_idx_reg == 2'd0) | ~rd_reg);
   wire do_tx = ~ack_slot & matched_reg & rd_reg & (byte_idx_reg != 2'd0);

   // Open-drain data driven on the falling link clock
   always_ff @(negedge bus_clk or negedge link_rst_n_reg) begin
      if (!link_rst_n_reg) begin
         sda_oe_reg <= 1'b0;
         sda_out_reg <= 1'b0;
      end else begin
         sda_oe_reg <= do_ack | (do_tx & ~rd_word[tx_idx]);
         sda_out_reg <= 1'b0;
      end
   end

   assign bus_sda_out = sda_out_reg;
   assign bus_sda_oe = sda_oe_reg;
   assign track_hold = track_hold_reg;
   assign ref_amp_en = ref_amp_en_reg;
   assign int_ref_sel = int_ref_sel_reg;
   assign power_down = power_down_reg;
   assign mux_sel = mux_sel_reg;
   assign over_temp = over_temp_reg;

   // Checks on the core clock, except the address acknowledge check on the link clock
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!arst_n);
   property p_pin_hold;
      (cst_fall && is_idle && !shutdown) |=> track_hold_reg ##1 track_hold_reg;
   endproperty
   a_pin_hold: assert property (p_pin_hold) else $error("no hold");
   property p_access_wait;
      (stop_det && is_idle && auto_on) |=> !track_hold_reg [*8];
   endproperty
   a_access_wait: assert property (p_access_wait) else $error("early");
   property p_hold_delay;
      $rose(track_hold_reg) && $past(state_reg) == tsc_pkg::ST_WAIT
         |-> $past(cnt_reg, 2) == 17'(tsc_pkg::HOLD_CYC - 2);
   endproperty
   a_hold_delay: assert property (p_hold_delay) else $error("delay");
   property p_conv_len;
      conv_done |-> cnt_reg == ((conv_chan_reg == 3'h0)
         ? 17'(TEMP_CONV_CYC - 1) : 17'(tsc_pkg::ADC_CONV_CYC - 1));
   endproperty
   a_conv_len: assert property (p_conv_len) else $error("length");
   property p_result_fmt;
      temp_reading_reg[5:0] == 6'h00;
   endproperty
   a_result_fmt: assert property (p_result_fmt) else $error("format");
   property p_no_torn;
      $changed(temp_reading_reg) |-> !$past(frame_active_reg);
   endproperty
   a_no_torn: assert property (p_no_torn) else $error("torn");
   property p_over;
      (apply && pend_temp_reg && over_lim) |=> over_reg;
   endproperty
   a_over: assert property (p_over) else $error("over limit");
   property p_ref_amp;
      ref_amp_en_reg |-> track_hold_reg && !int_ref_sel_reg == 1'b0;
   endproperty
   a_ref_amp: assert property (p_ref_amp) else $error("reference");
   property p_pdown;
      $fell(track_hold_reg) |-> power_down_reg;
   endproperty
   a_pdown: assert property (p_pdown) else $error("power");
   property p_pin_mode;
      pin_mode |-> !timer_go && !access_go;
   endproperty
   a_pin_mode: assert property (p_pin_mode) else $error("mode");
   property p_mux;
      $changed(cfg_core_reg) |=> mux_sel_reg == cfg_chan;
   endproperty
   a_mux: assert property (p_mux) else $error("channel");
   property p_addr_ack;
      @(posedge bus_clk) disable iff (!link_rst_n_reg)
         (ack_slot && byte_idx_reg == 2'd0 && sda_oe_reg) |-> matched_reg;
   endproperty
   a_addr_ack: assert property (p_addr_ack) else $error("address");
   c_pin_conv: cover property (pin_go ##1 track_hold_reg);
   c_access_conv: cover property (access_go);
   c_deferred: cover property (conv_done && frame_active_reg);
   c_over: cover property ($rose(over_reg));
endmodule
`default_nettype wire

/* hw/tsc_pkg.sv */
// Constants and types for the temperature sensor conversion control
package tsc_pkg;
   // Core clock rate and documented times in their own units
   localparam int CLK_MHZ = 200;
   localparam int HOLD_DELAY_US = 3;
   localparam int ADC_CONV_US = 15;
   localparam int TEMP_CONV_US = 30;
   localparam int AUTO_PERIOD_US = 355;
   // Cycle counts derived from the times
   localparam int HOLD_CYC = HOLD_DELAY_US * CLK_MHZ;
   localparam int ADC_CONV_CYC = ADC_CONV_US * CLK_MHZ;
   localparam int TEMP_CONV_CYC = TEMP_CONV_US * CLK_MHZ;
   localparam int AUTO_PERIOD_CYC = AUTO_PERIOD_US * CLK_MHZ;
   localparam int CNT_W = 17;
   // Register pointer values
   localparam logic [2:0] REG_TEMP = 3'h0;
   localparam logic [2:0] REG_CFG = 3'h1;
   localparam logic [2:0] REG_THYST = 3'h2;
   localparam logic [2:0] REG_TOTI = 3'h3;
   localparam logic [2:0] REG_ADC = 3'h4;
   localparam logic [2:0] REG_CFG2 = 3'h5;
   // Field positions
   localparam int CFG_CHAN_LSB = 5;
   localparam int CFG_POL_BIT = 2;
   localparam int CFG_SHDN_BIT = 0;
   localparam int CFG2_MODE_BIT = 7;
   localparam int RES_LSB = 6;
   localparam int SETP_LSB = 7;
   localparam logic [2:0] TEMP_CHAN = 3'h0;
   // Values after reset
   localparam logic [7:0] CFG_RST = 8'h00;
   localparam logic [7:0] CFG2_RST = 8'h00;
   localparam logic [15:0] THYST_RST = 16'h4b00;
   localparam logic [15:0] TOTI_RST = 16'h5000;
   localparam logic [15:0] RESULT_RST = 16'h0000;
   // Serial byte framing
   localparam logic [3:0] BIT_LAST = 4'h7;
   localparam logic [3:0] BIT_ACK = 4'h8;
   // Synchronised pin indices
   localparam int PIN_SCL = 0;
   localparam int PIN_SDA = 1;
   localparam int PIN_CST = 2;
   localparam int PIN_REF = 3;
   typedef enum logic [1:0] {ST_IDLE, ST_WAIT, ST_CONV} tsc_state_t;
endpackage
